// ===== pkg/mcr_cfg.svh
`ifndef MCR_CFG_SVH
`define MCR_CFG_SVH

// register byte offsets
`define MCR_OFF_BLK_COUNT 8'h00
`define MCR_OFF_BLK_REM 8'h04
`define MCR_OFF_RX_DATA 8'h08
`define MCR_OFF_TX_DATA 8'h0c
`define MCR_OFF_CMD 8'h10
`define MCR_OFF_ARG 8'h14
`define MCR_OFF_BLOCK_LENGTH_BYTES 8'h18
`define MCR_OFF_STATUS 8'h1c

// reset values
`define MCR_BLK_REM_RST 16'h0fff
`define MCR_BLOCK_LENGTH_BYTES_RST 12'h200

// command register fields
`define MCR_CMD_MASK 32'h0001_ffbf
`define MCR_CMD_DMA_BIT 16
`define MCR_CMD_READY_FLAG_CLEAR_BIT 15
`define MCR_CMD_WDATX_BIT 13
`define MCR_CMD_STRM_BIT 12
`define MCR_CMD_DTRW_BIT 11
`define MCR_CMD_STOP_INDEX 6'h0c

// status register fields
`define MCR_ST_RX_READY_BIT 0
`define MCR_ST_TX_READY_BIT 1
`define MCR_ST_ACTIVE_BIT 2

// bus answers
`define MCR_RESP_OKAY 2'b00
`define MCR_RESP_SLVERR 2'b10

`endif

// ===== pkg/mcr_pkg.sv
package mcr_pkg;

    typedef logic [3:0][7:0] mcr_word_t;

    // command and argument handed to the card link
    typedef struct packed {
        logic [31:0] word;
        logic [31:0] arg;
    } mcr_cmd_t;

    typedef struct packed {
        mcr_word_t [1:0] mem;
        logic wr_ptr;
        logic rd_ptr;
        logic [1:0] count;
    } mcr_buf_t;

    typedef struct packed {
        logic aw_have;
        logic [7:0] awaddr;
        logic w_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [15:0] blk_count;
        logic [15:0] blk_rem;
        logic [11:0] block_length_bytes;
        logic [31:0] arg;
        logic [31:0] cmd;
        mcr_word_t rx_word;
        mcr_word_t tx_word;
        logic rx_ready;
        logic tx_ready;
        logic tx_full;
        logic active;
        logic dir_wr;
        logic infinite;
        logic [1:0] lane;
        logic [11:0] byte_cnt;
        mcr_word_t asm_word;
        logic asm_valid;
        logic cmd_start;
        logic data_done;
    } mcr_state_t;

endpackage

// ===== design/mcr_buf2.sv
module mcr_buf2 (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire mcr_pkg::mcr_word_t in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output mcr_pkg::mcr_word_t out_data
);
    import mcr_pkg::*;

    mcr_buf_t s, n;

    assign in_ready = (s.count != 2'd2);
    assign out_valid = (s.count != 2'd0);
    assign out_data = s.mem[s.rd_ptr];

    always_comb begin
        n = s;
        if (in_valid && in_ready) begin
            n.mem[s.wr_ptr] = in_data;
            n.wr_ptr = ~s.wr_ptr;
        end
        if (out_valid && out_ready) begin
            n.rd_ptr = ~s.rd_ptr;
        end
        case ({in_valid && in_ready, out_valid && out_ready})
            2'b10: n.count = s.count + 2'd1;
            2'b01: n.count = s.count - 2'd1;
            default: n.count = s.count;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    chk_buf_bound: assert property (@(posedge aclk) disable iff (!aresetn)
        s.count <= 2'd2)
        else $error("buffer count out of range");
endmodule

// ===== design/mcr_regs.sv
`include "mcr_cfg.svh"

module mcr_regs (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // command launch towards the card link
    output mcr_pkg::mcr_cmd_t cmd_issue,
    output logic cmd_start,
    // card receive byte stream
    input wire logic card_rx_valid,
    output logic card_rx_ready,
    input wire logic [7:0] card_rx_byte,
    // card transmit byte stream
    output logic card_tx_valid,
    input wire logic card_tx_ready,
    output logic [7:0] card_tx_byte,
    // transfer progress and dma events
    output logic data_done,
    output logic dma_rx_event,
    output logic dma_tx_event
);
    import mcr_pkg::*;

    mcr_state_t s, n;
    logic do_wr, cmd_wr, rd_take, byte_go, last_byte, word_end;
    logic buf_in_ready, buf_out_valid, buf_out_ready;
    logic [11:0] block_length_bytes_wr;
    mcr_word_t buf_out_data;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // length field after strobes; upper bits are reserved and dropped
    assign block_length_bytes_wr = 12'(merge({20'h0, s.block_length_bytes}, s.wdata, s.wstrb));

    assign awready = !s.aw_have;
    assign wready = !s.w_have;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = !s.rvalid;
    assign rvalid = s.rvalid;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
    assign cmd_issue.word = s.cmd;
    assign cmd_issue.arg = s.arg;
    assign cmd_start = s.cmd_start;
    assign data_done = s.data_done;

    assign do_wr = s.aw_have && s.w_have && !s.bvalid;
    assign cmd_wr = do_wr && (s.awaddr == `MCR_OFF_CMD);
    assign rd_take = arvalid && arready;
    assign card_rx_ready = s.active && !s.dir_wr && !s.asm_valid;
    assign card_tx_valid = s.active && s.dir_wr && s.tx_full;
    assign card_tx_byte = s.tx_word[s.lane];
    assign byte_go = (card_rx_valid && card_rx_ready)
                  || (card_tx_valid && card_tx_ready);
    // block length sets bytes per block
    assign last_byte = (s.byte_cnt == s.block_length_bytes - 12'd1);
    assign word_end = (s.lane == 2'd3) || last_byte;
    assign buf_out_ready = !s.rx_ready;
    assign dma_rx_event = s.cmd[`MCR_CMD_DMA_BIT] && s.rx_ready;
    assign dma_tx_event = s.cmd[`MCR_CMD_DMA_BIT] && s.tx_ready
                       && s.active && s.dir_wr;

    mcr_buf2 u_rx_buf (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(s.asm_valid),
        .in_ready(buf_in_ready),
        .in_data(s.asm_word),
        .out_valid(buf_out_valid),
        .out_ready(buf_out_ready),
        .out_data(buf_out_data)
    );

    always_comb begin
        n = s;
        n.cmd_start = 1'b0;
        n.data_done = 1'b0;
        if (awvalid && awready) begin
            n.aw_have = 1'b1;
            n.awaddr = awaddr;
        end
        if (wvalid && wready) begin
            n.w_have = 1'b1;
            n.wdata = wdata;
            n.wstrb = wstrb;
        end
        if (s.bvalid && bready) begin
            n.bvalid = 1'b0;
        end
        if (s.rvalid && rready) begin
            n.rvalid = 1'b0;
        end
        if (do_wr) begin
            n.aw_have = 1'b0;
            n.w_have = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = `MCR_RESP_OKAY;
            case (s.awaddr)
                `MCR_OFF_BLK_COUNT: begin
                    n.blk_count = 16'(merge({16'h0, s.blk_count},
                                            s.wdata, s.wstrb));
                end
                `MCR_OFF_RX_DATA: begin
                    n.rx_word = merge(s.rx_word, s.wdata, s.wstrb);
                end
                `MCR_OFF_TX_DATA: begin
                    n.tx_word = merge(s.tx_word, s.wdata, s.wstrb);
                    n.tx_full = 1'b1;
                    n.tx_ready = 1'b0;
                end
                `MCR_OFF_ARG: begin
                    n.arg = merge(s.arg, s.wdata, s.wstrb);
                end
                `MCR_OFF_BLOCK_LENGTH_BYTES: begin
                    if (block_length_bytes_wr != 12'h0) begin
                        n.block_length_bytes = block_length_bytes_wr;
                    end
                end
                `MCR_OFF_CMD: begin
                    n.cmd = merge(s.cmd, s.wdata, s.wstrb) & `MCR_CMD_MASK;
                    n.cmd_start = 1'b1;
                    if (n.cmd[`MCR_CMD_READY_FLAG_CLEAR_BIT]) begin
                        n.rx_ready = 1'b0;
                        n.tx_ready = 1'b0;
                    end
                    if (n.cmd[`MCR_CMD_WDATX_BIT]) begin
                        n.blk_rem = s.blk_count;
                        n.active = 1'b1;
                        n.dir_wr = n.cmd[`MCR_CMD_DTRW_BIT];
                        n.infinite = n.cmd[`MCR_CMD_STRM_BIT]
                                  || (s.blk_count == 16'h0);
                        n.lane = 2'd0;
                        n.byte_cnt = 12'd0;
                        n.asm_word = '0;
                        n.asm_valid = 1'b0;
                        if (n.dir_wr && !s.tx_full) begin
                            n.tx_ready = 1'b1;
                        end
                    end else if (n.cmd[5:0] == `MCR_CMD_STOP_INDEX) begin
                        n.active = 1'b0;
                    end
                end
                `MCR_OFF_BLK_REM, `MCR_OFF_STATUS: begin
                    n.bresp = `MCR_RESP_OKAY;
                end
                default: n.bresp = `MCR_RESP_SLVERR;
            endcase
        end
        if (rd_take) begin
            n.rvalid = 1'b1;
            n.rresp = `MCR_RESP_OKAY;
            n.rdata = 32'h0;
            case (araddr)
                `MCR_OFF_BLK_COUNT: n.rdata = {16'h0, s.blk_count};
                `MCR_OFF_BLK_REM: n.rdata = {16'h0, s.blk_rem};
                `MCR_OFF_RX_DATA: begin
                    n.rdata = s.rx_word;
                    n.rx_ready = 1'b0;
                end
                `MCR_OFF_TX_DATA: n.rdata = s.tx_word;
                `MCR_OFF_ARG: n.rdata = s.arg;
                `MCR_OFF_BLOCK_LENGTH_BYTES: n.rdata = {20'h0, s.block_length_bytes};
                `MCR_OFF_CMD: n.rdata = s.cmd;
                `MCR_OFF_STATUS: begin
                    n.rdata[`MCR_ST_RX_READY_BIT] = s.rx_ready;
                    n.rdata[`MCR_ST_TX_READY_BIT] = s.tx_ready;
                    n.rdata[`MCR_ST_ACTIVE_BIT] = s.active;
                end
                default: n.rresp = `MCR_RESP_SLVERR;
            endcase
        end
        if (s.asm_valid && buf_in_ready) begin
            n.asm_valid = 1'b0;
            n.asm_word = '0;
        end
        // buffered word moves to receive register
        if (buf_out_valid && buf_out_ready) begin
            n.rx_word = buf_out_data;
            n.rx_ready = 1'b1;
        end
        if (byte_go) begin
            n.lane = s.lane + 2'd1;
            n.byte_cnt = s.byte_cnt + 12'd1;
            if (!s.dir_wr) begin
                // byte placed by lane, first byte lowest
                n.asm_word[s.lane] = card_rx_byte;
                n.asm_valid = word_end;
            end else if (word_end
                         && !(do_wr && s.awaddr == `MCR_OFF_TX_DATA)) begin
                // outgoing word consumed, ask for next
                n.tx_full = 1'b0;
                n.tx_ready = 1'b1;
            end
            if (last_byte) begin
                n.lane = 2'd0;
                n.byte_cnt = 12'd0;
                n.data_done = 1'b1;
                if (!s.infinite) begin
                    n.blk_rem = s.blk_rem - 16'd1;
                    // stop after the last counted block
                    if (s.blk_rem == 16'd1) begin
                        n.active = 1'b0;
                    end
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.blk_rem <= `MCR_BLK_REM_RST;
            s.block_length_bytes <= `MCR_BLOCK_LENGTH_BYTES_RST;
        end else begin
            s <= n;
        end
    end

    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_stop_ends_stream: assert property (
        cmd_wr && s.wdata[5:0] == `MCR_CMD_STOP_INDEX
        && !s.wdata[`MCR_CMD_WDATX_BIT] && s.wstrb == 4'hf |=> !s.active)
        else $error("stop command did not end transfer");
    chk_count_stop: assert property (
        byte_go && last_byte && !s.infinite && s.blk_rem == 16'd1
        && !cmd_wr |=> !s.active ##1 !card_rx_ready && !card_tx_valid)
        else $error("transfer ran past block count");
    chk_count_read: assert property (
        rd_take && araddr == `MCR_OFF_BLK_COUNT
        |=> s.rvalid && s.rdata == {16'h0, $past(s.blk_count)})
        else $error("block count readback wrong");
    chk_rem_decrement: assert property (
        byte_go && last_byte && !s.infinite && !cmd_wr
        |=> s.blk_rem == $past(s.blk_rem) - 16'd1)
        else $error("remaining blocks not decremented");
    chk_rem_reset: assert property (
        !$past(aresetn) |-> s.blk_rem == 16'h0fff && s.rx_word == 32'h0)
        else $error("reset values wrong");
    chk_rx_lane_zero: assert property (
        card_rx_valid && card_rx_ready && s.lane == 2'd0
        |=> s.asm_word[0] == $past(card_rx_byte))
        else $error("first byte not in low lane");
    chk_tx_low_first: assert property (
        card_tx_valid && s.lane == 2'd0 |-> card_tx_byte == s.tx_word[0])
        else $error("transmit not least byte first");
    chk_cmd_launch: assert property (
        cmd_wr |=> cmd_start && cmd_issue.arg == $past(s.arg)
        ##1 !cmd_start || $past(cmd_wr))
        else $error("command write did not launch");
    chk_cmd_kept: assert property (
        cmd_start && !cmd_wr |=> s.cmd == $past(s.cmd))
        else $error("command register changed after issue");
    chk_clear_flags: assert property (
        cmd_wr && s.wdata[`MCR_CMD_READY_FLAG_CLEAR_BIT] && s.wstrb[1]
        && !(buf_out_valid && buf_out_ready) && !byte_go
        |=> !s.rx_ready && (!s.tx_ready
            || s.cmd[`MCR_CMD_WDATX_BIT] && s.cmd[`MCR_CMD_DTRW_BIT]))
        else $error("data clear left ready flags set");
    chk_dma_gate: assert property (
        !s.cmd[`MCR_CMD_DMA_BIT] |-> !dma_rx_event && !dma_tx_event)
        else $error("dma event while disabled");
    chk_block_length_bytes_nonzero: assert property (
        s.block_length_bytes != 12'h0)
        else $error("block length became zero");
    chk_rem_load: assert property (
        cmd_wr && s.wdata[`MCR_CMD_WDATX_BIT] && s.wstrb[1]
        |=> s.blk_rem == $past(s.blk_count) && s.active)
        else $error("counter not loaded at data start");

    cov_multi_block: cover property (
        data_done && !s.active && !s.infinite);
    cov_stream_stop: cover property (
        s.active && s.infinite ##[1:200] !s.active);
    cov_rx_word: cover property ($rose(s.rx_ready));
    cov_tx_word: cover property (card_tx_valid && card_tx_ready);
endmodule

// ===== tb/mcr_card_model.sv
module mcr_card_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // pace: high makes the card stall every other cycle
    input wire logic slow,
    // bytes from the card
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [7:0] rx_byte,
    // bytes to the card
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_byte,
    // what the card has moved so far
    output logic [7:0] rx_count,
    output logic [7:0] tx_count,
    output logic [7:0] tx_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tick;
    assign tx_ready = !slow || tick;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick <= 1'b0;
            rx_valid <= 1'b0;
            rx_byte <= 8'hff;
            rx_count <= 8'h00;
            tx_count <= 8'h00;
            tx_seen <= 8'h00;
        end else begin
            tick <= ~tick;
            // card bytes run 0, 1, 2 ... held until taken
            if (rx_valid && rx_ready) begin
                rx_valid <= 1'b0;
                // released line shows the inverse of the last byte
                rx_byte <= ~rx_byte;
                rx_count <= rx_count + 8'h01;
            end else if (!rx_valid && tx_ready) begin
                rx_valid <= 1'b1;
                rx_byte <= rx_count;
            end
            if (tx_valid && tx_ready) begin
                tx_seen <= tx_byte;
                tx_count <= tx_count + 8'h01;
            end
        end
    end
endmodule

// ===== tb/testbench.sv
`include "mcr_cfg.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import mcr_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, slow = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, cmd_start, data_done;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, got;
    mcr_cmd_t cmd_issue, last_cmd;
    logic rx_v, rx_r, tx_v, tx_r, dma_rx_event, dma_tx_event;
    logic [7:0] rx_b, tx_b, rx_count, tx_count, tx_seen;
    int errors = 0, checks_done = 0, starts = 0, dones = 0, i;
    localparam logic [7:0] RST_ADDR [6] = '{8'h00, 8'h04, 8'h08, 8'h0c,
        8'h10, 8'h18};
    localparam logic [31:0] RST_VAL [6] = '{32'h0, 32'h0fff, 32'h0, 32'h0,
        32'h0, 32'h200};

    initial begin
        forever #20 aclk = ~aclk;
    end

    mcr_regs mcr_regs_inst (.aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .cmd_issue(cmd_issue), .cmd_start(cmd_start),
        .card_rx_valid(rx_v), .card_rx_ready(rx_r), .card_rx_byte(rx_b),
        .card_tx_valid(tx_v), .card_tx_ready(tx_r), .card_tx_byte(tx_b),
        .data_done(data_done), .dma_rx_event(dma_rx_event),
        .dma_tx_event(dma_tx_event));

    mcr_card_model mcr_card_model_inst (.aclk(aclk), .aresetn(aresetn),
        .slow(slow), .rx_valid(rx_v), .rx_ready(rx_r), .rx_byte(rx_b),
        .tx_valid(tx_v), .tx_ready(tx_r), .tx_byte(tx_b),
        .rx_count(rx_count), .tx_count(tx_count), .tx_seen(tx_seen));

    // counts command launches and finished blocks
    always @(posedge aclk) begin
        if (!aresetn) begin
            starts <= 0;
            dones <= 0;
        end else begin
            if (cmd_start === 1'b1) begin
                starts <= starts + 1;
                last_cmd <= cmd_issue;
            end
            if (data_done === 1'b1) dones <= dones + 1;
        end
    end

    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] seen);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic expire(input string what);
        errors++;
        $display("mismatch %s expected answer seen timeout", what);
        finish_test();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hf;
        bready <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                resp = bresp;
                bready <= 1'b0;
                return;
            end
        end
        expire("write response");
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge aclk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                got = rdata;
                resp = rresp;
                rready <= 1'b0;
                return;
            end
        end
        expire("read answer");
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp,
        input string what);
        rd(a);
        check(what, exp, got);
    endtask

    // 0: receive event, 1: transmit event, 2: card has k bytes
    task automatic wait_for(input int sel, input logic [7:0] k);
        int n;
        for (n = 0; n < 400; n++) begin
            @(posedge aclk);
            if (sel == 0 && dma_rx_event === 1'b1) return;
            if (sel == 1 && dma_tx_event === 1'b1) return;
            if (sel == 2 && tx_count === k) return;
        end
        expire("event wait");
    endtask

    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
    endtask

    function automatic logic [31:0] word_at(input int n);
        logic [7:0] b;
        b = 8'(4 * n);
        return {b + 8'h03, b + 8'h02, b + 8'h01, b};
    endfunction

    initial begin
        do_reset();
        for (i = 0; i < 6; i++) begin
            rchk(RST_ADDR[i], RST_VAL[i], "reset value");
        end
        wr(`MCR_OFF_BLK_COUNT, 32'hffff_ffff);
        rchk(`MCR_OFF_BLK_COUNT, 32'h0000_ffff, "count field");
        wr(`MCR_OFF_BLK_REM, 32'h0000_1234);
        rchk(`MCR_OFF_BLK_REM, 32'h0fff, "remaining read-only");
        wr(`MCR_OFF_BLOCK_LENGTH_BYTES, 32'h0);
        rchk(`MCR_OFF_BLOCK_LENGTH_BYTES, 32'h200, "zero length refused");
        rd(8'h20);
        check("unmapped read", 32'h2, {30'h0, resp});
        wr(8'h20, 32'h1);
        check("unmapped write", 32'h2, {30'h0, resp});
        // command launch with its argument
        wr(`MCR_OFF_ARG, 32'h1234_5678);
        wr(`MCR_OFF_CMD, 32'h0000_0001);
        rchk(`MCR_OFF_CMD, 32'h0000_0001, "command kept");
        check("launches", 32'd1, 32'(starts));
        check("launch arg", 32'h1234_5678, last_cmd.arg);
        wr(`MCR_OFF_CMD, 32'hffff_ffff);
        rchk(`MCR_OFF_CMD, 32'h0001_ffbf, "command mask");
        check("relaunch", 32'd2, 32'(starts));
        check("launch word", 32'h0001_ffbf, last_cmd.word);
        // counted read of three 8-byte blocks, reader stalls first
        do_reset();
        slow <= 1'b1;
        wr(`MCR_OFF_BLOCK_LENGTH_BYTES, 32'h8);
        wr(`MCR_OFF_BLK_COUNT, 32'h3);
        wr(`MCR_OFF_CMD, 32'h0001_2012);
        rchk(`MCR_OFF_BLK_REM, 32'h3, "count loaded");
        repeat (80) @(posedge aclk);
        check("bytes held back", 32'd16, 32'(rx_count));
        for (i = 0; i < 6; i++) begin
            wait_for(0, 8'h00);
            rchk(`MCR_OFF_RX_DATA, word_at(i), "rx word");
        end
        check("rx event idle", 32'h0, {31'h0, dma_rx_event});
        rchk(`MCR_OFF_BLK_REM, 32'h0, "count at end");
        rd(`MCR_OFF_STATUS);
        check("counted stop", 32'h0, got & 32'h4);
        check("bytes moved", 32'd24, 32'(rx_count));
        check("blocks done", 32'd3, 32'(dones));
        // zero count runs until the stop command
        do_reset();
        slow <= 1'b0;
        wr(`MCR_OFF_BLOCK_LENGTH_BYTES, 32'h4);
        wr(`MCR_OFF_CMD, 32'h0001_2001);
        for (i = 0; i < 5; i++) begin
            wait_for(0, 8'h00);
            rchk(`MCR_OFF_RX_DATA, word_at(i), "endless word");
        end
        rd(`MCR_OFF_STATUS);
        check("still active", 32'h4, got & 32'h4);
        wr(`MCR_OFF_CMD, 32'h0000_000c);
        rd(`MCR_OFF_STATUS);
        check("stopped", 32'h0, got & 32'h4);
        // one-block write, card stalling
        do_reset();
        slow <= 1'b1;
        wr(`MCR_OFF_BLOCK_LENGTH_BYTES, 32'h4);
        wr(`MCR_OFF_BLK_COUNT, 32'h1);
        wr(`MCR_OFF_CMD, 32'h0001_2818);
        wait_for(1, 8'h00);
        wr(`MCR_OFF_TX_DATA, 32'h4433_2211);
        wait_for(2, 8'h01);
        check("first byte out", 32'h11, 32'(tx_seen));
        wait_for(2, 8'h04);
        check("last byte out", 32'h44, 32'(tx_seen));
        rchk(`MCR_OFF_TX_DATA, 32'h4433_2211, "tx word");
        check("write block done", 32'd1, 32'(dones));
        check("tx event idle", 32'h0, {31'h0, dma_tx_event});
        finish_test();
    end
endmodule
